// ### testbench/sfe_chk_sva.sv
// Purpose: Concurrent checks on the serial link and the device status outputs
// Assumes: One ref_clk_in domain, nrst_in asynchronous and active low
// Notes: Erase lengths come from the parameters handed on by the bench
`timescale 1ns/100ps
module sfe_chk #(
  parameter int BLOCK_ERASE_CYC = 200,
  parameter int CHIP_ERASE_CYC = 400
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic [2:0] protect_range_bits_in,
  input wire logic write_in_progress_out,
  input wire logic write_enable_latch_out,
  input wire logic deep_sleep_out,
  input wire logic erase_start_out,
  input wire logic erase_chip_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  int bsy_cnt;
  logic was_chip;
  // Busy length counter; two cycles of slack cover the pin synchronisers
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bsy_cnt <= 0;
      was_chip <= 1'b0;
    end else if (erase_start_out) begin
      bsy_cnt <= 1;
      was_chip <= erase_chip_out;
    end else if (write_in_progress_out) begin
      bsy_cnt <= bsy_cnt + 1;
    end
  end
  AST_SCLK_IDLE: assert property ($fell(cs_n) |-> !sclk) else $error("clock not low at select");
  AST_SCLK_SEL: assert property ($changed(sclk) |-> !cs_n) else $error("clock moved while deselected");
  AST_SO_REL: assert property ($rose(cs_n) |-> ##[1:6] so_oe_n) else $error("output not released");
  AST_SO_FALL: assert property ($changed(so) && !so_oe_n |-> !sclk) else $error("output moved on high clock");
  AST_START_OK: assert property (erase_start_out |-> cs_n && $past(write_enable_latch_out))
    else $error("erase started without latch or select");
  AST_WEL_CLR: assert property (erase_start_out |-> ##[0:2] !write_enable_latch_out)
    else $error("latch not cleared by erase");
  AST_WIP_SET: assert property (erase_start_out |-> ##[0:1] write_in_progress_out)
    else $error("busy not raised by erase");
  AST_CHIP_BP: assert property (erase_chip_out |-> erase_start_out && protect_range_bits_in == 3'h0)
    else $error("chip erase under protection");
  AST_BLK_LEN: assert property ($fell(write_in_progress_out) && !was_chip |->
    bsy_cnt >= BLOCK_ERASE_CYC - 2 && bsy_cnt <= BLOCK_ERASE_CYC + 2) else $error("block erase length wrong");
  AST_CHIP_LEN: assert property ($fell(write_in_progress_out) && was_chip |->
    bsy_cnt >= CHIP_ERASE_CYC - 2 && bsy_cnt <= CHIP_ERASE_CYC + 2) else $error("chip erase length wrong");
  AST_SLEEP_IDLE: assert property ($rose(deep_sleep_out) |-> !write_in_progress_out && cs_n)
    else $error("sleep entered while busy");
endmodule // sfe_chk

// ### testbench/tb_serial_flash_erase_power_id_cmds.sv
// Purpose: Host and device ends joined, plus a spare device fed by raw frames
// Assumes: Erase counts shortened; host guard covers the wake delays
// Notes: Reads are matched against queued notes by a separate monitor
`timescale 1ns/100ps
module tb_serial_flash_erase_power_id_cmds;
  import sfe_pkg::*;
  localparam int BLK = 3000;
  localparam int CHP = 6000;
  localparam logic [7:0] MK = 8'hA5; // Arbitrary value
  localparam logic [7:0] PT = 8'h3C; // Arbitrary value
  localparam logic [7:0] MT = 8'h41; // Arbitrary value
  localparam logic [7:0] CP = 8'h17; // Arbitrary value
  localparam logic [127:0] UID = 128'hC3A5_1E0F_9B72_6D48_0F1E_2D3C_4B5A_6978; // Arbitrary value
  typedef struct {logic [31:0] e; logic [31:0] m;} sfe_note_s;
  logic ref_clk_in = 1'b0;
  logic nrst_in, av_rd, av_wr, av_wait, busy, wen, slp, est, ech, b_wen, b_est;
  logic [2:0] av_addr, bp, blk, b_blk;
  logic [31:0] av_wdata, av_rdata, q_dmy;
  logic [7:0] exp_op, wire_sh;
  int err_count, checks, wire_n, est_n, exp_n, b_n;
  sfe_note_s notes[$];
  sfe_note_s nt;
  sfe_if lk();
  sfe_if bl();
  always #2 ref_clk_in = ~ref_clk_in;
  sfe_dev #(.BLOCK_ERASE_CYC(BLK), .CHIP_ERASE_CYC(CHP), .MAKER_ID(MK), .PART_ID(PT), .MEM_TYPE(MT),
    .CAPACITY(CP), .UNIQUE_ID(UID)) sfe_dev_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .link(lk),
    .protect_range_bits_in(bp), .write_in_progress_out(busy), .write_enable_latch_out(wen),
    .deep_sleep_out(slp), .erase_start_out(est), .erase_chip_out(ech), .erase_block_out(blk));
  // Spare device: three of its five frames raise select after a wrong bit count on purpose
  sfe_dev #(.BLOCK_ERASE_CYC(BLK), .CHIP_ERASE_CYC(CHP)) sfe_dev_f_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .link(bl), .protect_range_bits_in(3'h0), .write_in_progress_out(), .write_enable_latch_out(b_wen),
    .deep_sleep_out(), .erase_start_out(b_est), .erase_chip_out(), .erase_block_out(b_blk));
  sfe_host #(.SCLK_HALF(10), .GUARD(750)) sfe_host_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .link(lk),
    .avm_address_in(av_addr), .avm_read_in(av_rd), .avm_write_in(av_wr), .avm_writedata_in(av_wdata),
    .avm_readdata_out(av_rdata), .avm_waitrequest_out(av_wait));
  sfe_chk #(.BLOCK_ERASE_CYC(BLK), .CHIP_ERASE_CYC(CHP)) sfe_chk_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .cs_n(lk.cs_n), .sclk(lk.sclk), .so(lk.so), .so_oe_n(lk.so_oe_n), .protect_range_bits_in(bp),
    .write_in_progress_out(busy), .write_enable_latch_out(wen), .deep_sleep_out(slp),
    .erase_start_out(est), .erase_chip_out(ech));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait for a level; a lapse is a mismatch
  task automatic hold(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v) begin
      @(posedge ref_clk_in);
      n++;
      if (n > lim) begin
        err_count++;
        end_sim();
      end
    end
  endtask
  // One bus access; on reads d is the expected value under mask m
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d, input logic [31:0] m,
    output logic [31:0] q);
    if (!wr) notes.push_back('{d, m});
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= !wr;
    @(posedge ref_clk_in);
    hold(av_wait, 1'b0, 100);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // One serial frame; polls busy so the host guard time is kept
  task automatic xf(input logic [7:0] op, input logic [2:0] ns, input logic [4:0] nr, input logic [23:0] ad);
    logic [31:0] q;
    int n;
    exp_op = op;
    av(1'b1, REG_ADDR, {8'h00, ad}, '0, q);
    av(1'b1, REG_CTRL, {1'b1, 10'h000, nr, 5'h00, ns, op}, '0, q);
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0) begin
      av(1'b0, REG_CTRL, '0, '0, q);
      n++;
      if (n > 3000) begin
        err_count++;
        end_sim();
      end
    end
  endtask
  task automatic st(input logic [7:0] e);
    xf(OP_READ_STATUS, 3'h1, 5'h01, 24'h0);
    av(1'b0, REG_RX0, {24'h0, e}, 32'h0000_00FF, q_dmy);
  endtask
  // Raw frame on the spare link with any bit count, MSB first
  task automatic bb(input logic [39:0] d, input int n);
    bl.cs_n <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    for (int i = 0; i < n; i++) begin
      bl.si <= d[39 - i];
      repeat (10) @(posedge ref_clk_in);
      bl.sclk <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      bl.sclk <= 1'b0;
    end
    repeat (10) @(posedge ref_clk_in);
    bl.cs_n <= 1'b1;
    bl.si <= ~bl.si;
    repeat (40) @(posedge ref_clk_in);
  endtask
  function automatic logic prot(input int b, input int k);
    return b != 0 && (b > 3 || k >= 8 - (1 << (b - 1)));
  endfunction
  // Read completions take the oldest note; erase pulses are counted
  always @(posedge ref_clk_in) begin
    if (av_rd && av_wait === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.m != 0) chk("readdata", av_rdata & nt.m, nt.e & nt.m);
    end
    if (est === 1'b1) est_n++;
    if (b_est === 1'b1) b_n++;
  end
  always @(posedge lk.sclk) begin
    if (!lk.cs_n && wire_n < 8) begin
      wire_sh = {wire_sh[6:0], lk.si};
      wire_n++;
    end
  end
  always @(negedge lk.cs_n) begin
    wire_n = 0;
    chk("sclk idle", {31'h0, lk.sclk}, 32'h0);
  end
  always @(posedge lk.cs_n) begin
    if (wire_n == 8) chk("opcode", {24'h0, wire_sh}, {24'h0, exp_op});
  end
  initial begin
    logic [23:0] a;
    int b;
    logic p;
    void'($urandom(9787));
    {av_rd, av_wr, av_addr, av_wdata, bp, exp_op} = '0;
    {bl.cs_n, bl.sclk, bl.si} = 3'b100;
    nrst_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    st(8'h00);
    av(1'b0, 3'h6, '0, 32'hFFFF_FFFF, q_dmy);
    for (int i = 1; i <= 3; i++) begin
      xf(OP_JEDEC_ID, 3'h1, 5'(i), 24'h0);
      av(1'b0, REG_RX0, {8'h0, MK, MT, CP} >> (8 * (3 - i)), ~(32'hFFFF_FFFF << (8 * i)), q_dmy);
    end
    for (int i = 0; i < 2; i++) begin
      xf(OP_MAKER_PART, 3'h4, 5'h02, 24'(i));
      av(1'b0, REG_RX0, i ? {16'h0, PT, MK} : {16'h0, MK, PT}, 32'h0000_FFFF, q_dmy);
    end
    xf(OP_WAKE_ID, 3'h4, 5'h03, 24'h0);
    av(1'b0, REG_RX0, {8'h0, PT, PT, PT}, 32'h00FF_FFFF, q_dmy);
    xf(OP_UNIQUE_ID, 3'h5, 5'h10, 24'h0);
    for (int i = 0; i < 4; i++) av(1'b0, 3'(REG_RX0 + i), UID[32 * i +: 32], 32'hFFFF_FFFF, q_dmy);
    repeat (4) begin
      b = $urandom_range(0, 4);
      a = 24'($urandom) & 24'h07_FFFF;
      p = prot(b, a[18:16]);
      bp <= 3'(b);
      xf(OP_WRITE_ENABLE, 3'h1, 5'h00, 24'h0);
      st({3'h0, 3'(b), 2'b10});
      xf(OP_BLOCK_ERASE, 3'h4, 5'h00, a);
      st({3'h0, 3'(b), p ? 2'b10 : 2'b01});
      if (!p) begin
        exp_n++;
        chk("block", {29'h0, blk}, {29'h0, a[18:16]});
        xf(OP_DEEP_SLEEP, 3'h1, 5'h00, 24'h0);
        xf(OP_JEDEC_ID, 3'h1, 5'h01, 24'h0);
        av(1'b0, REG_RX0, 32'hFF, 32'hFF, q_dmy);
        hold(busy, 1'b0, 8000);
        chk("sleep", {31'h0, slp}, 32'h0);
      end
    end
    for (int i = 0; i < 4; i++) begin
      b = i < 2 ? i + 3 : 0;
      bp <= 3'(b);
      xf(OP_WRITE_ENABLE, 3'h1, 5'h00, 24'h0);
      xf(i % 2 ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A, 3'h1, 5'h00, 24'h0);
      st({3'h0, 3'(b), b ? 2'b10 : 2'b01});
      if (b == 0) exp_n++;
      hold(busy, 1'b0, 8000);
    end
    xf(OP_CHIP_ERASE_B, 3'h1, 5'h00, 24'h0);
    st(8'h00);
    xf(OP_DEEP_SLEEP, 3'h2, 5'h00, 24'h0);
    repeat (20) @(posedge ref_clk_in);
    chk("sleep", {31'h0, slp}, 32'h0);
    xf(OP_DEEP_SLEEP, 3'h1, 5'h00, 24'h0);
    repeat (20) @(posedge ref_clk_in);
    chk("sleep", {31'h0, slp}, 32'h1);
    xf(OP_WRITE_ENABLE, 3'h1, 5'h00, 24'h0);
    xf(OP_CHIP_ERASE_A, 3'h1, 5'h00, 24'h0);
    xf(OP_WAKE_ID, 3'h1, 5'h00, 24'h0);
    repeat (20) @(posedge ref_clk_in);
    chk("sleep", {31'h0, slp}, 32'h0);
    st(8'h00);
    xf(OP_DEEP_SLEEP, 3'h1, 5'h00, 24'h0);
    repeat (20) @(posedge ref_clk_in);
    xf(OP_WAKE_ID, 3'h4, 5'h01, 24'h0);
    av(1'b0, REG_RX0, {24'h0, PT}, 32'h0000_00FF, q_dmy);
    repeat (20) @(posedge ref_clk_in);
    chk("sleep", {31'h0, slp}, 32'h0);
    chk("starts", est_n, exp_n);
    bb({8'h06, 32'h0}, 8);
    bb({8'hD8, 24'h02_0000, 8'h0}, 31);
    bb({8'hD8, 24'h02_0000, 8'h0}, 33);
    bb({8'hC7, 32'h0}, 7);
    chk("spare starts", b_n, 0);
    chk("spare latch", {31'h0, b_wen}, 32'h1);
    bb({8'hD8, 24'h05_1234, 8'h0}, 32);
    chk("spare starts", b_n, 1);
    chk("spare block", {29'h0, b_blk}, 32'h5);
    end_sim();
  end
endmodule // tb_serial_flash_erase_power_id_cmds

// ### verilog/sfe_dev.sv
// Purpose: Flash device end: erase, deep sleep, wake and ID read commands
// Assumes: Link pins are asynchronous to ref_clk_in and are synchronised here
// Notes: Opcodes 06H and 05H are decoded too, for the status bits
// Notes on behaviour
// - D8H plus three address bytes erases block
// - Block erase needs select rise after bit 32
// - Erase is self-timed; busy flag shows it
// - Write enable latch clears before erase ends
// - Erases run only with write enable set
// - Protected block is never erased
// - 60H or C7H, select rise after bit 8
// - Chip erase only with protection bits zero
// - B9H enters deep sleep after entry delay
// - Deep sleep ignores everything except ABH
// - Deep sleep refused while cycle busy
// - Reset always leaves the device in standby
// - ABH alone wakes after wake delay
// - ABH with dummies repeats device ID
// - Host waits wake ID delay after ID wake
// - ABH ignored while write in progress
// - 90H address picks maker or part first
// - 9FH gives maker, type, capacity bytes
// - 9FH not decoded while cycle busy
// - Select rise ends any ID output
// - Host avoids 9FH during deep sleep
// - 4BH gives 128-bit unique value
// - Input bits sampled on serial clock rise
`timescale 1ns/100ps
module sfe_dev #(
  parameter int BLOCK_ERASE_CYC = sfe_pkg::BLOCK_ERASE_CYC,
  parameter int CHIP_ERASE_CYC = sfe_pkg::CHIP_ERASE_CYC,
  parameter logic [7:0] MAKER_ID = 8'h5A,       // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h12,        // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h34,       // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h13,       // Arbitrary value
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEFFEDCBA9876543210 // Arbitrary value
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  sfe_if.dev link,
  input wire logic [2:0] protect_range_bits_in,
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic deep_sleep_out,
  output logic erase_start_out,
  output logic erase_chip_out,
  output logic [2:0] erase_block_out
);
  import sfe_pkg::*;

  logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, si_s1, si_s2;
  logic sck_rise, sck_fall, cs_rise;
  logic [5:0] bit_cnt;
  logic [39:0] rx_sr;
  logic [7:0] opcode;
  logic cmd_ok;
  logic [7:0] cur_op;
  logic cur_ok;
  logic [5:0] cur_cnt;
  logic [23:0] cur_addr;
  logic load_go;
  logic [127:0] load_val;
  logic [7:0] load_len;
  logic [127:0] out_sr;
  logic [7:0] out_len;
  logic [6:0] out_idx;
  logic out_act;
  logic [31:0] erase_cnt;
  logic [31:0] sleep_cnt;
  logic [31:0] wake_cnt;
  logic asleep, sleep_pend, waking, blk_prot;
  logic [7:0] status_byte;

  // Two-stage synchronisers on every link input
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
    end else begin
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      sck_s1 <= link.sclk;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      si_s1 <= link.si;
      si_s2 <= si_s1;
    end
  end

  // Serial clock edges seen only while selected
  assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
  assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;
  assign cs_rise = cs_s2 & ~cs_d;
  assign waking = (wake_cnt != 32'h0);
  assign status_byte = {3'h0, protect_range_bits_in, write_enable_latch_out, write_in_progress_out};

  // Opcode and address as they stand after the current rising edge
  always_comb begin
    cur_cnt = bit_cnt + 6'h01;
    cur_op = (bit_cnt == 6'h07) ? {rx_sr[6:0], si_s2} : opcode;
    cur_addr = {rx_sr[22:0], si_s2};
    if (waking) begin
      cur_ok = 1'b0; // Nothing is taken while waking up
    end else if (asleep) begin
      cur_ok = (cur_op == OP_WAKE_ID);
    end else if (write_in_progress_out) begin
      cur_ok = (cur_op == OP_READ_STATUS);
    end else begin
      cur_ok = 1'b1;
    end
  end

  // Which ID or status stream starts, and when
  always_comb begin
    load_go = 1'b0;
    load_val = 128'h0;
    load_len = OUT_BYTE;
    if (sck_rise && cur_ok && bit_cnt != LEN_SAT) begin
      case (cur_op)
        OP_READ_STATUS: begin
          load_go = (cur_cnt == LEN_CMD);
          load_val = {status_byte, 120'h0};
        end
        OP_JEDEC_ID: begin
          load_go = (cur_cnt == LEN_CMD);
          load_val = {MAKER_ID, MEM_TYPE, CAPACITY, 104'h0};
          load_len = OUT_JEDEC;
        end
        OP_WAKE_ID: begin
          load_go = (cur_cnt == LEN_ADDR);
          load_val = {PART_ID, 120'h0};
        end
        OP_MAKER_PART: begin
          load_go = (cur_cnt == LEN_ADDR);
          load_val = cur_addr[0] ? {PART_ID, MAKER_ID, 112'h0} : {MAKER_ID, PART_ID, 112'h0};
          load_len = OUT_PAIR;
        end
        OP_UNIQUE_ID: begin
          load_go = (cur_cnt == LEN_ADDR_DUMMY);
          load_val = UNIQUE_ID;
          load_len = OUT_UNIQUE;
        end
        default: load_go = 1'b0;
      endcase
    end
  end

  // Input shift; deselect clears the count so partial commands vanish
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt <= 6'h0;
      rx_sr <= 40'h0;
      opcode <= 8'h0;
      cmd_ok <= 1'b0;
    end else if (cs_s2) begin
      bit_cnt <= 6'h0;
    end else if (sck_rise) begin
      rx_sr <= {rx_sr[38:0], si_s2};
      if (bit_cnt != LEN_SAT) begin
        bit_cnt <= cur_cnt;
      end
      if (bit_cnt == 6'h07) begin
        opcode <= cur_op;
        cmd_ok <= cur_ok;
      end
    end
  end

  // Output stream, repeating within its length until deselect
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_sr <= 128'h0;
      out_len <= OUT_BYTE;
      out_idx <= 7'h0;
      out_act <= 1'b0;
      link.so <= 1'b0;
      link.so_oe_n <= 1'b1;
    end else if (cs_s2) begin
      out_act <= 1'b0;
      link.so_oe_n <= 1'b1;
    end else if (load_go) begin
      out_sr <= load_val;
      out_len <= load_len;
      out_idx <= 7'h0;
      out_act <= 1'b1;
    end else if (sck_fall && out_act) begin
      link.so <= out_sr[7'd127 - out_idx];
      link.so_oe_n <= 1'b0;
      out_idx <= (({1'b0, out_idx} + 8'h01) == out_len) ? 7'h0 : out_idx + 7'h01;
    end
  end

  // Block protection: 1..3 guard the top 1, 2, 4 blocks, 4 and up all
  always_comb begin
    case (protect_range_bits_in)
      3'h0: blk_prot = 1'b0;
      3'h1: blk_prot = (rx_sr[BLK_ADDR_LSB+2:BLK_ADDR_LSB] == 3'h7);
      3'h2: blk_prot = (rx_sr[BLK_ADDR_LSB+2:BLK_ADDR_LSB] >= 3'h6);
      3'h3: blk_prot = (rx_sr[BLK_ADDR_LSB+2:BLK_ADDR_LSB] >= 3'h4);
      default: blk_prot = 1'b1;
    endcase
  end

  // Write enable latch and erase cycle; latch clears as the cycle starts
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      write_enable_latch_out <= 1'b0;
      write_in_progress_out <= 1'b0;
      erase_cnt <= 32'h0;
      erase_start_out <= 1'b0;
      erase_chip_out <= 1'b0;
      erase_block_out <= 3'h0;
    end else begin
      erase_start_out <= 1'b0;
      erase_chip_out <= 1'b0;
      if (write_in_progress_out) begin
        erase_cnt <= erase_cnt - 32'h1;
        if (erase_cnt == 32'h1) begin
          write_in_progress_out <= 1'b0;
        end
      end else if (cs_rise && cmd_ok) begin
        if (opcode == OP_WRITE_ENABLE && bit_cnt == LEN_CMD) begin
          write_enable_latch_out <= 1'b1;
        end
        if (opcode == OP_BLOCK_ERASE && bit_cnt == LEN_ADDR
            && write_enable_latch_out && !blk_prot) begin
          write_in_progress_out <= 1'b1;
          write_enable_latch_out <= 1'b0;
          erase_cnt <= BLOCK_ERASE_CYC;
          erase_start_out <= 1'b1;
          erase_block_out <= rx_sr[BLK_ADDR_LSB+2:BLK_ADDR_LSB];
        end
        if ((opcode == OP_CHIP_ERASE_A || opcode == OP_CHIP_ERASE_B) && bit_cnt == LEN_CMD
            && write_enable_latch_out && protect_range_bits_in == 3'h0) begin
          write_in_progress_out <= 1'b1;
          write_enable_latch_out <= 1'b0;
          erase_cnt <= CHIP_ERASE_CYC;
          erase_start_out <= 1'b1;
          erase_chip_out <= 1'b1;
        end
      end
    end
  end

  // Deep sleep entry, residence and wake; reset lands in standby
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      asleep <= 1'b0;
      sleep_pend <= 1'b0;
      sleep_cnt <= 32'h0;
      wake_cnt <= 32'h0;
      deep_sleep_out <= 1'b0;
    end else begin
      deep_sleep_out <= asleep;
      if (waking) begin
        wake_cnt <= wake_cnt - 32'h1;
      end
      if (sleep_pend) begin
        sleep_cnt <= sleep_cnt - 32'h1;
        if (sleep_cnt == 32'h1) begin
          sleep_pend <= 1'b0;
          asleep <= 1'b1;
        end
      end else if (cs_rise && cmd_ok && !write_in_progress_out) begin
        if (opcode == OP_DEEP_SLEEP && bit_cnt == LEN_CMD && !asleep) begin
          sleep_pend <= 1'b1;
          sleep_cnt <= SLEEP_ENTRY_CYC;
        end
        if (opcode == OP_WAKE_ID && asleep) begin
          asleep <= 1'b0;
          wake_cnt <= (bit_cnt == LEN_CMD) ? WAKE_CYC : WAKE_ID_CYC;
        end
      end
    end
  end
endmodule // sfe_dev

// ### verilog/sfe_host.sv
// Purpose: Host controller end: Avalon-MM orders become serial flash transfers
// Assumes: Software writes ADDR then CTRL with the go bit, polls busy
// Notes: After each deselect the host stays busy for the longest wake delay
`timescale 1ns/100ps
module sfe_host #(
  parameter int SCLK_HALF = sfe_pkg::SCLK_HALF_CYC,
  parameter int GUARD = sfe_pkg::GUARD_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  sfe_if.host link,
  input wire logic [2:0] avm_address_in,
  input wire logic avm_read_in,
  input wire logic avm_write_in,
  input wire logic [31:0] avm_writedata_in,
  output logic [31:0] avm_readdata_out,
  output logic avm_waitrequest_out
);
  import sfe_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_LAST = 3'b011,
    ST_GUARD = 3'b100
  } sfe_state_e;

  sfe_state_e state;
  logic ack;
  logic [23:0] addr;
  logic [39:0] tx_sr;
  logic [127:0] rx_sr;
  logic [8:0] bits_left;
  logic [7:0] half_cnt;
  logic tick;
  logic [31:0] guard_cnt;
  logic so_s1, so_s2;
  logic go;

  // One wait cycle per access; request is taken when waitrequest is low
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack <= 1'b0;
      avm_waitrequest_out <= 1'b1;
      avm_readdata_out <= 32'h0;
    end else begin
      ack <= (avm_read_in | avm_write_in) & ~ack;
      avm_waitrequest_out <= ~((avm_read_in | avm_write_in) & ~ack);
      if (avm_read_in && !ack) begin
        if (avm_address_in == REG_CTRL) begin
          avm_readdata_out <= {31'h0, state != ST_IDLE};
        end else if (avm_address_in == REG_ADDR) begin
          avm_readdata_out <= {8'h0, addr};
        end else if (avm_address_in >= REG_RX0 && avm_address_in <= REG_RX3) begin
          avm_readdata_out <= rx_sr[32 * (avm_address_in - REG_RX0) +: 32];
        end else begin
          avm_readdata_out <= 32'h0; // Unmapped reads return zero
        end
      end
    end
  end

  assign go = avm_write_in && ack && avm_address_in == REG_CTRL && avm_writedata_in[CTRL_GO_BIT];

  // Address register
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr <= 24'h0;
    end else if (avm_write_in && ack && avm_address_in == REG_ADDR) begin
      addr <= avm_writedata_in[23:0];
    end
  end

  // Serial output from the device passes two flip-flops
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      so_s1 <= 1'b0;
      so_s2 <= 1'b0;
    end else begin
      so_s1 <= link.so | link.so_oe_n; // Idle line reads high
      so_s2 <= so_s1;
    end
  end

  // Half-period divider; restarts with each transfer
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      half_cnt <= 8'h0;
    end else if (state == ST_IDLE || tick) begin
      half_cnt <= 8'h0;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end
  assign tick = (half_cnt == 8'(SCLK_HALF - 1));

  // Transfer sequencer: mode 0, MSB first, deselect half a period after the last clock fall
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.si <= 1'b0;
      tx_sr <= 40'h0;
      rx_sr <= 128'h0;
      bits_left <= 9'h0;
      guard_cnt <= 32'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go && avm_writedata_in[10:8] != 3'h0) begin // Busy writes of go are ignored
            tx_sr <= {avm_writedata_in[7:0], addr, 8'h00};
            link.si <= avm_writedata_in[7];
            bits_left <= {1'b0, avm_writedata_in[20:16] + {2'h0, avm_writedata_in[10:8]}, 3'h0};
            link.cs_n <= 1'b0;
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            link.sclk <= 1'b1;
            rx_sr <= {rx_sr[126:0], so_s2};
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            link.sclk <= 1'b0;
            bits_left <= bits_left - 9'h001;
            tx_sr <= {tx_sr[38:0], 1'b0};
            link.si <= tx_sr[38];
            state <= (bits_left == 9'h001) ? ST_LAST : ST_LOW;
          end
        end
        ST_LAST: begin
          if (tick) begin
            link.cs_n <= 1'b1;
            guard_cnt <= GUARD;
            state <= ST_GUARD;
          end
        end
        ST_GUARD: begin
          guard_cnt <= guard_cnt - 32'h1;
          if (guard_cnt <= 32'h1) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // sfe_host

// ### verilog/sfe_if.sv
// Purpose: Serial link between flash device end and host controller end
// Assumes: Both ends run on the same ref_clk_in and sample link pins
// Notes: so_oe_n low while the device drives its serial output
`timescale 1ns/100ps
interface sfe_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe_n;
  modport dev (input cs_n, input sclk, input si, output so, output so_oe_n);
  modport host (output cs_n, output sclk, output si, input so, input so_oe_n);
endinterface

// ### verilog/sfe_pkg.sv
// Purpose: Shared constants for the serial flash erase, power and ID command block
// Assumes: 250 MHz ref_clk_in; serial link timed by the host's serial clock
// Notes: Times are kept in their own unit; cycle counts are derived below
package sfe_pkg;
  localparam int CLK_MHZ = 250;
  // Command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  localparam logic [7:0] OP_MAKER_PART = 8'h90;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9F;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
  // Bit counts at which a command's input phase ends, and the count at which bit_cnt saturates
  localparam logic [5:0] LEN_CMD = 6'h08;
  localparam logic [5:0] LEN_ADDR = 6'h20;
  localparam logic [5:0] LEN_ADDR_DUMMY = 6'h28;
  localparam logic [5:0] LEN_SAT = 6'h3F;
  // Output lengths in bits
  localparam logic [7:0] OUT_BYTE = 8'h08;
  localparam logic [7:0] OUT_PAIR = 8'h10;
  localparam logic [7:0] OUT_JEDEC = 8'h18;
  localparam logic [7:0] OUT_UNIQUE = 8'h80;
  // Status byte layout and block number position in the address
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEN_BIT = 1;
  localparam int ST_BP_LSB = 2;
  localparam int BLK_ADDR_LSB = 16;
  // Self-timed durations
  localparam int BLOCK_ERASE_TIME_US = 500;
  localparam int CHIP_ERASE_TIME_US = 2000;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int WAKE_DELAY_NS = 3000;
  localparam int WAKE_ID_DELAY_NS = 3000;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC = (WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_ID_CYC = (WAKE_ID_DELAY_NS * CLK_MHZ + 999) / 1000;
  // Host side: serial clock half period, 80 ns full period
  localparam int SCLK_HALF_CYC = 10;
  localparam int GUARD_CYC = (WAKE_CYC > WAKE_ID_CYC) ? WAKE_CYC : WAKE_ID_CYC;
  // Host register word indices (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_RX0 = 3'h2;
  localparam logic [2:0] REG_RX3 = 3'h5;
  localparam int CTRL_GO_BIT = 31;
endpackage
